/* core/mcb_pkg.sv */
// Package: constants and carrier types for the master clock and interrupt board
package mcb_pkg;

	// Clock and derived rates
	localparam int unsigned SYS_CLK_HZ = 20000000;
	localparam int unsigned CTRL_CLK_HZ = 4000000;
	localparam int unsigned SLOW_CLK_HZ = 1000000;
	localparam int unsigned STROBE_NS = 50;
	localparam int unsigned NEXT_WORD_NS = 250;
	localparam int unsigned SYS_PERIOD_NS = 1000000000 / SYS_CLK_HZ;

	// Cycle counts derived from the rates
	localparam int unsigned DIV4M = SYS_CLK_HZ / CTRL_CLK_HZ;
	localparam int unsigned DIV1M = SYS_CLK_HZ / SLOW_CLK_HZ;
	localparam int unsigned STROBE_CYC = (STROBE_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
	localparam int unsigned NEXT_WORD_CYC = (NEXT_WORD_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;

	// Counter widths and limits
	localparam logic [2:0] DIV4M_LAST = 3'(DIV4M - 1);
	localparam logic [2:0] DIV4M_HALF = 3'(DIV4M / 2);
	localparam logic [4:0] DIV1M_LAST = 5'(DIV1M - 1);
	localparam logic [4:0] DIV1M_HALF = 5'(DIV1M / 2);
	localparam logic [2:0] NW_LEN = 3'(NEXT_WORD_CYC);
	localparam logic [2:0] STROBE_PHASE = 3'h0;

	// Bandwidth code: lag shift rate is 4 MHz / 2**code; code 7 gives 31.25 kHz
	localparam int BW_W = 3;
	localparam logic [BW_W-1:0] BW_RESET = 3'h0;
	localparam int LAG_DIV_W = 7;

	// Phase width of the fringe rotators
	localparam int PHASE_W = 8;

	// Correlator strobe outputs
	typedef struct packed {
		logic total_count_multiplier_strobe;
		logic [1:0] correlator_multiplier_strobes;
		logic [1:0] lag_shift_strobes;
	} mcb_strobes_t;

	// Square-wave clock outputs
	typedef struct packed {
		logic control_clock;
		logic [1:0] readout_shift_clock;
		logic total_count_clock;
		logic delay_display_clock;
	} mcb_clocks_t;

	// Host I/O bus interrupt and DMA lines
	typedef struct packed {
		logic host_interrupt_clock;
		logic interrupt_acknowledge_line;
		logic dma_input_request_b;
		logic dma_output_request_b;
		logic interrupt_taken_pulse;
		logic host_system_reset;
		logic processor_halted;
	} mcb_host_in_t;

	// Host interrupt controller states
	typedef enum logic [1:0] {
		MCB_IRQ_IDLE,
		MCB_IRQ_PENDING,
		MCB_IRQ_ACTIVE
	} mcb_irq_state_t;

endpackage

/* core/mcb_master_clock.sv */
// Module: master clock, next-word shaper, interrupt interlock, pulsed delay, B-C rotator
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// [RULE1] All timing divided from 20 MHz clock
// [RULE2] Continuous 4 MHz control square wave
// [RULE3] 4 MHz readout shift square wave
// [RULE4] 1 MHz square wave for total counters
// [RULE5] Separate 1 MHz delay display square wave
// [RULE6] 50 ns 4 MHz total-count multiplier strobe
// [RULE7] Two 50 ns 4 MHz multiplier strobes
// [RULE8] Two 50 ns lag strobes, bandwidth rate
// [RULE9] Host-loaded bandwidth register picks lag rate
// [RULE10] Next-word command gives aligned 250 ns pulse
// [RULE11] Next-word pulse active low to chain
// [RULE12] 60 Hz tick sets request when enabled
// [RULE13] Next interrupt clock raises interrupt line
// [RULE14] Acknowledge clears the request flip-flop
// [RULE15] DMA pending holds interrupt, blocks clear
// [RULE16] Waiting interrupt delivered after DMA serviced
// [RULE17] Interrupt taken clears interrupt enable
// [RULE18] Host sets and clears enable anytime
// [RULE19] Reset while halted clears enable
// [RULE20] No interrupt vector driven, location zero
// [RULE21] Retard deletes, advance inserts unload pulse
// [RULE22] Each step shifts B/C by 250 ns
// [RULE23] Difference rotator phase is C minus B
module mcb_master_clock (
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire logic [31:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic i_next_word_command,
	input wire logic i_tick_60hz,
	input wire mcb_pkg::mcb_host_in_t i_host,
	input wire logic [1:0] i_retard_pulse,
	input wire logic [1:0] i_advance_pulse,
	input wire logic [mcb_pkg::PHASE_W-1:0] i_phase_b,
	input wire logic [mcb_pkg::PHASE_W-1:0] i_phase_c,
	output mcb_pkg::mcb_clocks_t o_clocks,
	output mcb_pkg::mcb_strobes_t o_strobes,
	output logic o_readout_chain_serial_in_b,
	output logic o_interrupt_request_line,
	output logic [5:0] o_interrupt_address_select,
	output logic [1:0] o_buffer_unload_clock,
	output logic [mcb_pkg::PHASE_W-1:0] o_phase_bc
);

	// Register map (byte addresses on the Avalon slave)
	localparam logic [31:0] ADDR_BW = 32'h0000_0000;
	localparam logic [31:0] ADDR_IEN = 32'h0000_0004;
	localparam logic [31:0] ADDR_STATUS = 32'h0000_0008;
	localparam logic [31:0] ADDR_STEP = 32'h0000_000c;
	localparam logic [31:0] ADDR_CMD = 32'h0000_0010;
	localparam logic [31:0] UNMAPPED_DATA = 32'hdead_beef;

	logic [2:0] div4_reg;
	logic [4:0] div1_reg;
	logic [mcb_pkg::LAG_DIV_W-1:0] lag_reg;
	logic tick4;
	logic lag_tick;
	logic [mcb_pkg::BW_W-1:0] bw_reg;
	logic ien_sw_reg;
	logic ien_hw_reg;
	logic req_reg;
	logic int_reg;
	logic ick_d_reg;
	logic ick_rise;
	logic dma_pending;
	mcb_pkg::mcb_irq_state_t irq_state;
	logic nw_arm_reg;
	logic [2:0] nw_cnt_reg;
	logic [1:0] adv_pend_reg;
	logic [1:0] ret_pend_reg;
	logic [1:0] unload_reg;
	logic sw_next_word;
	logic [1:0] sw_retard;
	logic [1:0] sw_advance;
	logic bus_wr;
	logic bus_rd;
	logic rd_done_reg;
	logic ins_slot;
	logic [4:0] disp_div_reg;

	// Lag divider mask: bits of the prescaler that must be zero for a lag strobe
	function automatic logic [mcb_pkg::LAG_DIV_W-1:0] lag_mask(input logic [mcb_pkg::BW_W-1:0] code);
		lag_mask = mcb_pkg::LAG_DIV_W'((1 << code) - 1);
	endfunction

	// Write strobe for one register offset
	function automatic logic wr_hit(input logic wr, input logic [31:0] addr, input logic [31:0] offset);
		wr_hit = wr && (addr == offset);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Avalon-MM slave: writes land at once, reads stall one cycle for the data
	assign avs_waitrequest = bus_rd && !rd_done_reg;
	assign bus_wr = avs_write && !avs_read;
	assign bus_rd = avs_read && !avs_write;
	assign sw_next_word = wr_hit(bus_wr, avs_address, ADDR_CMD) && avs_writedata[0];
	assign sw_retard = wr_hit(bus_wr, avs_address, ADDR_STEP) ? avs_writedata[1:0] : 2'h0;
	assign sw_advance = wr_hit(bus_wr, avs_address, ADDR_STEP) ? avs_writedata[3:2] : 2'h0;

	// Read wait flag: high in the cycle in which the captured word stands
	// Without the stall the master would take the previous read's word
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rd_done_reg <= 1'b0;
		end else begin
			rd_done_reg <= bus_rd && !rd_done_reg;
		end
	end

	// Read data captured at the first read edge, stands at the ready edge
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			avs_readdata <= 32'h0;
		end else if (bus_rd && !rd_done_reg) begin
			case (avs_address)
				ADDR_BW: avs_readdata <= {29'h0, bw_reg};
				ADDR_IEN: avs_readdata <= {30'h0, ien_hw_reg, ien_sw_reg};
				ADDR_STATUS: avs_readdata <= {28'h0, dma_pending, int_reg, req_reg, nw_arm_reg};
				ADDR_STEP: avs_readdata <= {28'h0, adv_pend_reg, ret_pend_reg};
				ADDR_CMD: avs_readdata <= 32'h0;
				default: avs_readdata <= UNMAPPED_DATA;
			endcase
		end
	end

	// [RULE9] bandwidth register load
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			bw_reg <= mcb_pkg::BW_RESET;
		end else if (wr_hit(bus_wr, avs_address, ADDR_BW)) begin
			bw_reg <= avs_writedata[mcb_pkg::BW_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// [RULE1] 20 MHz dividers
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			div4_reg <= 3'h0;
			div1_reg <= 5'h0;
		end else begin
			div4_reg <= (div4_reg == mcb_pkg::DIV4M_LAST) ? 3'h0 : div4_reg + 3'h1;
			div1_reg <= (div1_reg == mcb_pkg::DIV1M_LAST) ? 5'h0 : div1_reg + 5'h1;
		end
	end

	// [RULE5] own divider for the display time base
	// Kept apart so the display can be retimed without touching the counters
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			disp_div_reg <= 5'h0;
		end else begin
			disp_div_reg <= (disp_div_reg == mcb_pkg::DIV1M_LAST) ? 5'h0 : disp_div_reg + 5'h1;
		end
	end

	// One-cycle enable once per 4 MHz period
	assign tick4 = (div4_reg == mcb_pkg::STROBE_PHASE);
	// Mid-period slot where an inserted unload pulse goes
	assign ins_slot = (div4_reg == mcb_pkg::DIV4M_HALF);

	// Lag prescaler counts 4 MHz ticks; bandwidth picks the division
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			lag_reg <= '0;
		end else if (tick4) begin
			lag_reg <= lag_reg + 1'b1;
		end
	end

	// [RULE8] lag strobe rate from bandwidth
	assign lag_tick = tick4 && ((lag_reg & lag_mask(bw_reg)) == '0);

	// [RULE2] square waves registered so no glitches reach the chassis
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_clocks <= '0;
		end else begin
			o_clocks.control_clock <= (div4_reg < mcb_pkg::DIV4M_HALF);
			// [RULE3] readout shift clock
			o_clocks.readout_shift_clock <= {2{div4_reg < mcb_pkg::DIV4M_HALF}};
			// [RULE4] total-count clock
			o_clocks.total_count_clock <= (div1_reg < mcb_pkg::DIV1M_HALF);
			// [RULE5] separate display time base
			o_clocks.delay_display_clock <= (disp_div_reg < mcb_pkg::DIV1M_HALF);
		end
	end

	// [RULE6] one-cycle 50 ns strobes; [RULE7] fixed 4 MHz regardless of bandwidth
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_strobes <= '0;
		end else begin
			o_strobes.total_count_multiplier_strobe <= tick4;
			o_strobes.correlator_multiplier_strobes <= {2{tick4}};
			o_strobes.lag_shift_strobes <= {2{lag_tick}};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// [RULE10] arm on command, start at multiplier strobe phase
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			nw_arm_reg <= 1'b0;
		end else if (i_next_word_command || sw_next_word) begin
			nw_arm_reg <= 1'b1;
		end else if (tick4 && nw_cnt_reg == 3'h0) begin
			nw_arm_reg <= 1'b0;
		end
	end

	// Width counter; a command during a pulse waits for the first strobe after the pulse ends
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			nw_cnt_reg <= 3'h0;
		end else if (nw_cnt_reg != 3'h0) begin
			nw_cnt_reg <= nw_cnt_reg - 3'h1;
		end else if (nw_arm_reg && tick4) begin
			nw_cnt_reg <= mcb_pkg::NW_LEN;
		end
	end

	// [RULE11] active low drive to readout chain
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_readout_chain_serial_in_b <= 1'b1;
		end else begin
			o_readout_chain_serial_in_b <= !((nw_cnt_reg > 3'h1) || (nw_arm_reg && tick4 && nw_cnt_reg == 3'h0));
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Host interrupt clock edge and DMA interlock
	// A transfer acknowledge also shows on the acknowledge line, so the
	// interlock must keep it from clearing a waiting interrupt request
	assign ick_rise = i_host.host_interrupt_clock && !ick_d_reg;
	assign dma_pending = !i_host.dma_input_request_b || !i_host.dma_output_request_b;

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ick_d_reg <= 1'b0;
		end else begin
			ick_d_reg <= i_host.host_interrupt_clock;
		end
	end

	// Enable flip-flops: software half and hardware half
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ien_sw_reg <= 1'b0;
			ien_hw_reg <= 1'b0;
		end else if (i_host.host_system_reset && i_host.processor_halted) begin
			// [RULE19] halted reset clears enable
			ien_sw_reg <= 1'b0;
			ien_hw_reg <= 1'b0;
		end else if (wr_hit(bus_wr, avs_address, ADDR_IEN)) begin
			// [RULE18] program sets or clears enable
			ien_sw_reg <= avs_writedata[0];
			ien_hw_reg <= avs_writedata[0];
		end else if (i_host.interrupt_taken_pulse) begin
			// [RULE17] taken pulse disables
			ien_hw_reg <= 1'b0;
		end
	end

	// Request flip-flop; a tick wins over an acknowledge in the same cycle
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			req_reg <= 1'b0;
		end else if (i_tick_60hz && ien_sw_reg && ien_hw_reg) begin
			// [RULE12] enabled tick sets request
			req_reg <= 1'b1;
		end else if (i_host.interrupt_acknowledge_line && !dma_pending) begin
			// [RULE14] acknowledge clears; [RULE15] not while DMA
			req_reg <= 1'b0;
		end
	end

	// Interrupt flip-flop, clocked by host interrupt clock edges
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			int_reg <= 1'b0;
		end else if (dma_pending) begin
			// [RULE15] held clear during DMA
			int_reg <= 1'b0;
		end else if (ick_rise) begin
			// [RULE13] set on interrupt clock; [RULE16] waiting one follows
			int_reg <= req_reg;
		end
	end

	// State view of the interlock; its ACTIVE state drives the interrupt request line
	always_comb begin
		case ({int_reg, req_reg})
			2'b01: irq_state = mcb_pkg::MCB_IRQ_PENDING;
			2'b11, 2'b10: irq_state = mcb_pkg::MCB_IRQ_ACTIVE;
			default: irq_state = mcb_pkg::MCB_IRQ_IDLE;
		endcase
	end

	assign o_interrupt_request_line = (irq_state == mcb_pkg::MCB_IRQ_ACTIVE);
	// [RULE20] no vector presented
	assign o_interrupt_address_select = 6'h00;

	////////////////////////////////////////////////////////////////////////////
	// [RULE21] pending delete per buffer, used at the next period start
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ret_pend_reg <= 2'h0;
		end else begin
			ret_pend_reg <= (ret_pend_reg & ~{2{tick4}}) | i_retard_pulse | sw_retard;
		end
	end

	// [RULE21] pending insert per buffer, used at the mid-period slot
	// Clearing at the period start would lose a request made after mid-period
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			adv_pend_reg <= 2'h0;
		end else begin
			adv_pend_reg <= (adv_pend_reg & ~{2{ins_slot}}) | i_advance_pulse | sw_advance;
		end
	end

	// [RULE22] one 250 ns unload step: extra pulse mid-period or suppressed pulse
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			unload_reg <= 2'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (tick4) begin
					unload_reg[i] <= !ret_pend_reg[i];
				end else if (ins_slot) begin
					unload_reg[i] <= adv_pend_reg[i];
				end else begin
					unload_reg[i] <= 1'b0;
				end
			end
		end
	end

	assign o_buffer_unload_clock = unload_reg;

	// [RULE23] difference rotator phase
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_phase_bc <= '0;
		end else begin
			o_phase_bc <= i_phase_c - i_phase_b;
		end
	end

endmodule

/* verification/mcb_monitor.sv */
// Checker: timing relations at the ports of the master clock board
`timescale 1ns/100ps
module mcb_monitor (
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire logic [mcb_pkg::PHASE_W-1:0] i_phase_b,
	input wire logic [mcb_pkg::PHASE_W-1:0] i_phase_c,
	input wire mcb_pkg::mcb_host_in_t i_host,
	input wire mcb_pkg::mcb_clocks_t o_clocks,
	input wire mcb_pkg::mcb_strobes_t o_strobes,
	input wire logic o_readout_chain_serial_in_b,
	input wire logic o_interrupt_request_line,
	input wire logic [5:0] o_interrupt_address_select,
	input wire logic [mcb_pkg::PHASE_W-1:0] o_phase_bc
);
	localparam int PW = mcb_pkg::PHASE_W;
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_b);
	////////////////////////////////////////////////////////////////////////////////
	// Strobe quiet for four cycles, then back
	sequence strobe_gap(x);
		!x [*4] ##1 x;
	endsequence
	// Shaped pulse low for exactly five cycles
	sequence nw_low;
		!o_readout_chain_serial_in_b [*5] ##1 o_readout_chain_serial_in_b;
	endsequence
	// Two cycles of a pending transfer, so the clear has landed
	sequence dma_wait;
		(!i_host.dma_input_request_b || !i_host.dma_output_request_b) [*2];
	endsequence
	////////////////////////////////////////////////////////////////////////////////
	a_ctrl_period: assert property ($rose(o_clocks.control_clock) |-> ##5 $rose(o_clocks.control_clock))
		else $error("control clock period wrong");
	a_shift_period: assert property ($rose(o_clocks.readout_shift_clock[0]) |-> ##5 $rose(o_clocks.readout_shift_clock[0]))
		else $error("readout shift clock period wrong");
	a_total_period: assert property ($rose(o_clocks.total_count_clock) |-> ##20 $rose(o_clocks.total_count_clock))
		else $error("total count clock period wrong");
	a_delay_period: assert property ($rose(o_clocks.delay_display_clock) |-> ##20 $rose(o_clocks.delay_display_clock))
		else $error("delay display clock period wrong");
	a_total_strobe: assert property ($rose(o_strobes.total_count_multiplier_strobe) |=> strobe_gap(o_strobes.total_count_multiplier_strobe))
		else $error("total count strobe spacing wrong");
	a_mult_strobe: assert property ($rose(o_strobes.correlator_multiplier_strobes[0]) |=> strobe_gap(o_strobes.correlator_multiplier_strobes[0]))
		else $error("multiplier strobe spacing wrong");
	a_word_length: assert property ($fell(o_readout_chain_serial_in_b) |-> nw_low)
		else $error("next word pulse length wrong");
	a_word_align: assert property ($fell(o_readout_chain_serial_in_b) |-> o_strobes.total_count_multiplier_strobe)
		else $error("next word pulse not aligned to strobe");
	a_irq_clock: assert property ($rose(o_interrupt_request_line) |-> $past(i_host.host_interrupt_clock))
		else $error("interrupt raised away from interrupt clock");
	a_dma_hold: assert property (dma_wait |-> !o_interrupt_request_line)
		else $error("interrupt line high during transfer");
	a_no_vector: assert property (o_interrupt_address_select == 6'h00)
		else $error("vector lines driven");
	a_phase_diff: assert property (1'b1 |=> o_phase_bc == PW'($past(i_phase_c) - $past(i_phase_b)))
		else $error("difference phase wrong");
endmodule
bind mcb_master_clock mcb_monitor i_mon (.i_sys_clk, .i_rst_b, .i_phase_b, .i_phase_c, .i_host, .o_clocks,
	.o_strobes, .o_readout_chain_serial_in_b, .o_interrupt_request_line, .o_interrupt_address_select, .o_phase_bc);

/* verification/mcb_host_model.sv */
// Host bus model: interrupt clock, acknowledge and taken pulse, DMA and reset lines
`timescale 1ns/100ps
module mcb_host_model (
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire logic i_irq,
	input wire logic [1:0] i_dma,
	input wire logic i_sysrst,
	output mcb_pkg::mcb_host_in_t o_host
);
	logic [3:0] cyc_reg;
	logic irq_reg;
	logic ack_reg;
	logic dma_d_reg;
	logic dack_reg;
	////////////////////////////////////////////////////////////////////////////////
	// Interrupt clock runs free, 16 cycles a period
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cyc_reg <= 4'h0;
			irq_reg <= 1'b0;
			ack_reg <= 1'b0;
			dma_d_reg <= 1'b0;
			dack_reg <= 1'b0;
		end else begin
			dma_d_reg <= |i_dma;
			// a transfer is acknowledged on the same line
			dack_reg <= (|i_dma) & !dma_d_reg;
			cyc_reg <= cyc_reg + 4'h1;
			irq_reg <= i_irq;
			ack_reg <= i_irq & !irq_reg;
		end
	end
	// Transfer requests are active low; halt follows reset so the pair is seen together
	assign o_host = '{cyc_reg[3], ack_reg | dack_reg, !i_dma[0], !i_dma[1], ack_reg, i_sysrst, i_sysrst};
endmodule

/* verification/tb.sv */
// Testbench: self-checking run of the master clock board
`timescale 1ns/100ps
module tb;
	logic i_sys_clk = 1'b0;
	logic i_rst_b;
	logic [31:0] adr = 32'h0, wdat = 32'h0, rdat, rd;
	logic rde = 1'b0, wre = 1'b0, wt, nw = 1'b0, tck = 1'b0, srst = 1'b0, nwb, irq;
	logic [1:0] rt = 2'h0, ad = 2'h0, dma = 2'h0, ucl, r, a;
	logic [7:0] pb = 8'h0, pc = 8'h0, pbc, ex = 8'h0;
	logic [5:0] ias;
	logic [11:0] cur, prv;
	mcb_pkg::mcb_host_in_t host;
	mcb_pkg::mcb_clocks_t clks;
	mcb_pkg::mcb_strobes_t stb;
	integer mismatches = 0, num_checks = 0, seed = 32'h893d3ce1, lo, per, run = 0;
	integer cnt [12];
	assign cur = {clks, stb, ucl};
	mcb_master_clock i_dut (.i_sys_clk, .i_rst_b, .avs_address(adr), .avs_read(rde), .avs_write(wre),
		.avs_writedata(wdat), .avs_readdata(rdat), .avs_waitrequest(wt), .i_next_word_command(nw),
		.i_tick_60hz(tck), .i_host(host), .i_retard_pulse(rt), .i_advance_pulse(ad), .i_phase_b(pb),
		.i_phase_c(pc), .o_clocks(clks), .o_strobes(stb), .o_readout_chain_serial_in_b(nwb),
		.o_interrupt_request_line(irq), .o_interrupt_address_select(ias), .o_buffer_unload_clock(ucl),
		.o_phase_bc(pbc));
	mcb_host_model u_host (.i_sys_clk, .i_rst_b, .i_irq(irq), .i_dma(dma), .i_sysrst(srst), .o_host(host));
	////////////////////////////////////////////////////////////////////////////////
	// 20 MHz clock
	initial forever #25 i_sys_clk = ~i_sys_clk;
	// Random phases; the registered difference lags one cycle
	always @(posedge i_sys_clk) begin
		if (run)
			chk(pbc, ex);
		ex = pc - pb;
		pb <= 8'($random(seed));
		pc <= 8'($random(seed));
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	// Bus cycle; data taken at the edge where waitrequest is low, then one idle edge
	task automatic bus(input logic w, input logic [31:0] ai, input logic [31:0] d);
		adr <= ai;
		wdat <= d;
		wre <= w;
		rde <= !w;
		@(posedge i_sys_clk);
		while (wt !== 1'b0)
			@(posedge i_sys_clk);
		rd = rdat;
		rde <= 1'b0;
		wre <= 1'b0;
		@(posedge i_sys_clk);
	endtask
	task automatic rdc(input logic [31:0] ai, input logic [31:0] e);
		bus(1'b0, ai, 32'h0);
		chk(rd, e);
	endtask
	task automatic tk;
		tck <= 1'b1;
		@(posedge i_sys_clk);
		tck <= 1'b0;
	endtask
	task automatic wirq(input logic e);
		for (int i = 0; i < 80 && irq !== e; i++)
			@(posedge i_sys_clk);
	endtask
	// Rising edges of every clock, strobe and unload line over n cycles
	task automatic meas(input int n);
		for (int i = 0; i < 12; i++)
			cnt[i] = 0;
		prv = cur;
		repeat (n) begin
			@(posedge i_sys_clk);
			for (int i = 0; i < 12; i++)
				cnt[i] += cur[i] & !prv[i];
			prv = cur;
		end
	endtask
	task automatic final_report;
		if (mismatches == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		i_rst_b = 1'b0;
		repeat (16) @(posedge i_sys_clk);
		i_rst_b <= 1'b1;
		@(posedge i_sys_clk);
		run <= 1;
		chk(ias, 0);
		rdc(0, 0);
		rdc(4, 0);
		rdc(32'h40, 32'hdeadbeef);
		// Every bandwidth code, counted over whole periods after settling
		for (int b = 0; b < 8; b++) begin
			bus(1'b1, 0, b);
			rdc(0, b);
			repeat (640) @(posedge i_sys_clk);
			meas(20 << b);
			for (int i = 0; i < 12; i++) begin
				per = (i == 7 || i == 8) ? 20 : (i == 2 || i == 3) ? 5 << b : 5;
				chk(cnt[i], (20 << b) / per);
			end
		end
		// Random delete and insert on B and C, by pins then by register
		for (int k = 0; k < 2; k++) begin
			r = 2'($random(seed));
			a = 2'($random(seed)) & ~r;
			fork
				meas(100);
				if (k)
					bus(1'b1, 12, {28'h0, a, r});
				else begin
					rt <= r;
					ad <= a;
					@(posedge i_sys_clk);
					rt <= 2'h0;
					ad <= 2'h0;
				end
			join
			for (int i = 0; i < 2; i++)
				chk(cnt[i], 20 - r[i] + a[i]);
		end
		// Next word by pin, then by command register
		for (int k = 0; k < 2; k++) begin
			if (k)
				bus(1'b1, 16, 1);
			else begin
				nw <= 1'b1;
				@(posedge i_sys_clk);
				nw <= 1'b0;
			end
			lo = 0;
			repeat (30) begin
				@(posedge i_sys_clk);
				lo += !nwb;
			end
			chk(lo, 5);
		end
		// Enabled tick delivered, accepted and cleared
		bus(1'b1, 4, 1);
		rdc(4, 3);
		tk;
		wirq(1'b1);
		chk(irq, 1);
		wirq(1'b0);
		rdc(8, 0);
		rdc(4, 1);
		bus(1'b1, 4, 0);
		tk;
		repeat (40) @(posedge i_sys_clk);
		chk(irq, 0);
		rdc(8, 0);
		// Input then output transfer pending holds the interrupt back; its acknowledge keeps the request
		for (int d = 1; d < 3; d++) begin
			bus(1'b1, 4, 1);
			dma <= 2'(d);
			tk;
			repeat (40) @(posedge i_sys_clk);
			chk(irq, 0);
			rdc(8, 32'ha);
			dma <= 2'h0;
			wirq(1'b1);
			chk(irq, 1);
			wirq(1'b0);
		end
		bus(1'b1, 4, 1);
		srst <= 1'b1;
		@(posedge i_sys_clk);
		srst <= 1'b0;
		rdc(4, 0);
		final_report;
	end
	// Watchdog well beyond the expected run
	initial begin
		#2000000;
		mismatches++;
		final_report;
	end
endmodule
